// ### alpr_pkg.sv
`default_nettype none
package alpr_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] ALPR_CFG_ADDR    = 8'h84;
  localparam logic [7:0] ALPR_RES_HI_ADDR = 8'h85;
  localparam logic [7:0] ALPR_RES_LO_ADDR = 8'h86;
  localparam logic [7:0] ALPR_UNMAPPED    = 8'h00;

  // ****************************************************
  // Field positions of the light configuration register
  // ****************************************************
  localparam int ALPR_CONT_POS = 7;
  localparam int ALPR_RATE_POS = 4;
  localparam int ALPR_OFFS_POS = 3;
  localparam int ALPR_AVG_POS  = 0;

  typedef struct packed {
    logic       cont;
    logic [2:0] rate;
    logic       offs_en;
    logic [2:0] avg;
  } alpr_cfg_t;

  localparam alpr_cfg_t ALPR_CFG_RESET = '{
    cont:    1'h0,
    rate:    3'h0,
    offs_en: 1'h1,
    avg:     3'h5
  };

  // ****************************************************
  // Timing defaults
  // ****************************************************
  localparam int unsigned ALPR_CLK_HZ = 25_000_000;
  localparam int          ALPR_DATA_W = 16;
  localparam int          ALPR_AVG_W  = 3;

  // ****************************************************
  // Measurement sequencer states
  // ****************************************************
  typedef enum logic [1:0] {
    ALPR_ST_IDLE  = 2'b00,
    ALPR_ST_OFFS  = 2'b01,
    ALPR_ST_CONV  = 2'b10,
    ALPR_ST_STORE = 2'b11
  } alpr_state_t;

  // Samples per second for a rate code
  function automatic int unsigned alpr_rate_sps(input logic [2:0] code);
    case (code)
      3'h6:    alpr_rate_sps = 8;
      3'h7:    alpr_rate_sps = 10;
      default: alpr_rate_sps = 32'(code) + 1;
    endcase
  endfunction

endpackage
`default_nettype wire

// ### alpr_avg.sv
`default_nettype none
module alpr_avg #(
  parameter int DATA_W = 16,
  parameter int LOG_W  = 3
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                clear,
  input  wire logic                sample_vld,
  input  wire logic [DATA_W-1:0]   sample,
  input  wire logic [LOG_W-1:0]    log2n,
  output logic                     last,
  output logic      [DATA_W-1:0]   avg
);

  localparam int MAXN  = 1 << ((1 << LOG_W) - 1);
  localparam int SUM_W = DATA_W + (1 << LOG_W) - 1;
  localparam int CNT_W = (1 << LOG_W) - 1;

  logic [SUM_W-1:0] sum_q;
  logic [SUM_W-1:0] total;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_last;

  // ****************************************************
  // Accumulate and divide by a power of two
  // ****************************************************
  assign total    = sum_q + SUM_W'(sample);
  assign cnt_last = CNT_W'((MAXN - 1) >> (CNT_W - 32'(log2n)));
  assign last     = sample_vld && (cnt_q == cnt_last);
  assign avg      = DATA_W'(total >> log2n);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= '0;
      cnt_q <= '0;
    end else if (clear || last) begin
      sum_q <= '0;
      cnt_q <= '0;
    end else if (sample_vld) begin
      sum_q <= total;
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

endmodule
`default_nettype wire

// ### alpr_top.sv
// How it works
// - Bit 7 repeats on-demand measurements, off at reset
// - Bit 3 enables offset compensation, on at reset
// - Offset measured first, subtracted from reading
// - Bits 2:0 give two-power conversion count
// - Result is average of all light conversions
// - Averaging field resets to 101, 32 conversions
// - Periodic mode applies new config after cycling
// - Result high byte at 85h, low 86h
// - Periodic enable blocks on-demand measurements
`default_nettype none
module alpr_top #(
  parameter int unsigned CLK_HZ_P = alpr_pkg::ALPR_CLK_HZ
) (
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  input  wire logic [7:0]                         reg_addr,
  input  wire logic                               reg_wr,
  input  wire logic [7:0]                         reg_wdata,
  output logic      [7:0]                         reg_rd_data,
  input  wire logic                               periodic_en,
  input  wire logic                               light_single_shot_trigger,
  output logic                                    conv_req,
  output logic                                    conv_offset,
  input  wire logic                               conv_done,
  input  wire logic [alpr_pkg::ALPR_DATA_W-1:0]   conv_data,
  output logic                                    light_busy,
  output logic                                    light_result_valid
);
  import alpr_pkg::*;

  localparam int DW = ALPR_DATA_W;

  alpr_cfg_t   cfg_q;
  alpr_cfg_t   act_q;
  alpr_state_t state_q;
  alpr_state_t state_d;
  logic [31:0]   period_cnt_q;
  logic [31:0]   period_last;
  logic          tick;
  logic          start;
  logic          cont_run_q;
  logic [DW-1:0] offset_q;
  logic [DW-1:0] result_q;
  logic [DW-1:0] avg;
  logic [DW-1:0] comp;
  logic          avg_last;
  logic          samp_vld;
  logic [7:0]    rd_data_q;
  logic          conv_req_q;
  logic          conv_offset_q;
  logic          valid_q;
  logic [7:0]    meas_cnt_q;
  logic          busy_q;

  function automatic logic [31:0] rate_period(input logic [2:0] code);
    rate_period = 32'(CLK_HZ_P / alpr_rate_sps(code));
  endfunction

  // ****************************************************
  // Configuration register and applied copy
  // ****************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= ALPR_CFG_RESET;
    end else if (reg_wr && reg_addr == ALPR_CFG_ADDR) begin
      cfg_q <= alpr_cfg_t'(reg_wdata);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= ALPR_CFG_RESET;
    end else if (!periodic_en && state_q == ALPR_ST_IDLE) begin
      act_q <= cfg_q;
    end
  end

  // ****************************************************
  // Periodic rate timer
  // ****************************************************
  assign period_last = rate_period(act_q.rate) - 32'd1;
  assign tick        = periodic_en && (period_cnt_q == period_last);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_q <= '0;
    end else if (!periodic_en || tick) begin
      period_cnt_q <= '0;
    end else begin
      period_cnt_q <= period_cnt_q + 32'd1;
    end
  end

  // ****************************************************
  // On-demand and continuous start
  // ****************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cont_run_q <= 1'b0;
    end else if (periodic_en || !act_q.cont) begin
      cont_run_q <= 1'b0;
    end else if (light_single_shot_trigger) begin
      cont_run_q <= 1'b1;
    end
  end

  always_comb begin
    if (periodic_en) begin
      start = tick;
    end else begin
      start = light_single_shot_trigger || cont_run_q;
    end
  end

  // ****************************************************
  // Measurement sequencer
  // ****************************************************
  assign samp_vld = (state_q == ALPR_ST_CONV) && conv_done;
  assign comp     = (avg > offset_q) ? avg - offset_q : '0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ALPR_ST_IDLE: begin
        if (start && act_q.offs_en) begin
          state_d = ALPR_ST_OFFS;
        end else if (start) begin
          state_d = ALPR_ST_CONV;
        end
      end
      ALPR_ST_OFFS: begin
        if (conv_done) begin
          state_d = ALPR_ST_CONV;
        end
      end
      ALPR_ST_CONV: begin
        if (avg_last) begin
          state_d = ALPR_ST_STORE;
        end
      end
      ALPR_ST_STORE: state_d = ALPR_ST_IDLE;
      default:       state_d = ALPR_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= ALPR_ST_IDLE;
      conv_req_q    <= 1'b0;
      conv_offset_q <= 1'b0;
      busy_q        <= 1'b0;
    end else begin
      state_q       <= state_d;
      conv_req_q    <= state_d == ALPR_ST_OFFS || state_d == ALPR_ST_CONV;
      conv_offset_q <= state_d == ALPR_ST_OFFS;
      busy_q        <= state_d != ALPR_ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      offset_q <= '0;
    end else if (state_q == ALPR_ST_IDLE) begin
      offset_q <= '0;
    end else if (state_q == ALPR_ST_OFFS && conv_done) begin
      offset_q <= conv_data;
    end
  end

  alpr_avg #(
    .DATA_W (DW),
    .LOG_W  (ALPR_AVG_W)
  ) u_avg (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .clear      (state_q == ALPR_ST_IDLE),
    .sample_vld (samp_vld),
    .sample     (conv_data),
    .log2n      (act_q.avg),
    .last       (avg_last),
    .avg        (avg)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
      valid_q  <= 1'b0;
    end else begin
      valid_q <= samp_vld && avg_last;
      if (samp_vld && avg_last) begin
        result_q <= comp;
      end
    end
  end

  // ****************************************************
  // Register read port
  // ****************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= ALPR_UNMAPPED;
    end else begin
      case (reg_addr)
        ALPR_CFG_ADDR:    rd_data_q <= cfg_q;
        ALPR_RES_HI_ADDR: rd_data_q <= result_q[15:8];
        ALPR_RES_LO_ADDR: rd_data_q <= result_q[7:0];
        default:          rd_data_q <= ALPR_UNMAPPED;
      endcase
    end
  end

  assign reg_rd_data        = rd_data_q;
  assign conv_req           = conv_req_q;
  assign conv_offset        = conv_offset_q;
  assign light_busy         = busy_q;
  assign light_result_valid = valid_q;

  // ****************************************************
  // Checks
  // ****************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meas_cnt_q <= '0;
    end else if (state_q == ALPR_ST_IDLE) begin
      meas_cnt_q <= '0;
    end else if (samp_vld) begin
      meas_cnt_q <= meas_cnt_q + 8'd1;
    end
  end

  chk_act_frozen: assert property (
    @(posedge mclk) disable iff (!rst_n)
    periodic_en && $past(periodic_en) |-> $stable(act_q))
    else $error("applied config changed during periodic mode");

  chk_act_follow: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !periodic_en && state_q == ALPR_ST_IDLE |=> act_q == $past(cfg_q))
    else $error("applied config not taken while idle");

  chk_single_block: assert property (
    @(posedge mclk) disable iff (!rst_n)
    periodic_en && state_q == ALPR_ST_IDLE && !tick
    |=> state_q == ALPR_ST_IDLE)
    else $error("measurement started without periodic tick");

  chk_offs_first: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_q == ALPR_ST_IDLE && start && act_q.offs_en
    |=> state_q == ALPR_ST_OFFS && conv_req && conv_offset)
    else $error("offset not measured first");

  chk_no_offs: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_q == ALPR_ST_IDLE && start && !act_q.offs_en
    |=> state_q == ALPR_ST_CONV && !conv_offset)
    else $error("offset measured while disabled");

  chk_avg_count: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_q == ALPR_ST_STORE |-> meas_cnt_q == 8'(1 << act_q.avg))
    else $error("wrong number of conversions");

  chk_store_sub: assert property (
    @(posedge mclk) disable iff (!rst_n)
    samp_vld && avg_last
    |=> light_result_valid && result_q == $past(comp))
    else $error("result not the compensated average");

  chk_result_hi: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_addr == ALPR_RES_HI_ADDR |=> reg_rd_data == $past(result_q[15:8]))
    else $error("result high byte mismatch");

  chk_result_lo: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_addr == ALPR_RES_LO_ADDR |=> reg_rd_data == $past(result_q[7:0]))
    else $error("result low byte mismatch");

  chk_rate_period: assert property (
    @(posedge mclk) disable iff (!rst_n)
    tick |-> period_cnt_q == rate_period(act_q.rate) - 32'd1)
    else $error("periodic tick off rate");

  chk_cont_repeat: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_q == ALPR_ST_STORE && cont_run_q && act_q.cont && !periodic_en
    ##1 !periodic_en |=> state_q != ALPR_ST_IDLE)
    else $error("continuous mode did not restart");

endmodule
`default_nettype wire

// ### alpr_conv_model.sv
`default_nettype none
module alpr_conv_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        conv_req,
  input  wire logic        conv_offset,
  input  wire logic [3:0]  delay,
  input  wire logic [15:0] light_val,
  input  wire logic [15:0] offs_val,
  output logic             conv_done,
  output logic [15:0]      conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       tog_q;
  // ****************************************************
  // Converter: done after delay, alternating light samples
  // ****************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= '0;
      tog_q     <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else if (!conv_req || conv_done) begin
      cnt_q     <= '0;
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (!conv_req) begin
        tog_q <= 1'b0;
      end
    end else if (cnt_q == delay) begin
      cnt_q     <= '0;
      conv_done <= 1'b1;
      if (conv_offset) begin
        conv_data <= offs_val;
      end else begin
        conv_data <= light_val + (tog_q ? 16'h0002 : 16'h0000);
        tog_q     <= ~tog_q;
      end
    end else begin
      cnt_q     <= cnt_q + 4'h1;
      conv_data <= ~conv_data;
    end
  end
endmodule
`default_nettype wire

// ### test_ambient_light_param_result.sv
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module test_ambient_light_param_result;
  timeunit 1ns;
  timeprecision 1ps;
  import alpr_pkg::*;
  localparam int unsigned CLK_P = 1000;
  logic        mclk = 1'b0;
  logic        rst_n, reg_wr, periodic_en, light_single_shot_trigger;
  logic [7:0]  reg_addr, reg_wdata, reg_rd_data;
  logic        conv_req, conv_offset, conv_done;
  logic [15:0] conv_data, light_val, offs_val;
  logic        light_busy, light_result_valid;
  logic [3:0]  delay;
  int          errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          done_cnt = 0;
  int          n0;
  // ****************************************************
  // Clock, cycle count, timeout
  // ****************************************************
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (conv_done === 1'b1) done_cnt++;
    if (cyc == 60000) begin
      errors++;
      summarize();
    end
  end
  alpr_top #(.CLK_HZ_P(CLK_P)) dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd_data(reg_rd_data), .periodic_en(periodic_en),
    .light_single_shot_trigger(light_single_shot_trigger),
    .conv_req(conv_req), .conv_offset(conv_offset),
    .conv_done(conv_done), .conv_data(conv_data),
    .light_busy(light_busy), .light_result_valid(light_result_valid));
  alpr_conv_model u_conv (.mclk(mclk), .rst_n(rst_n),
    .conv_req(conv_req), .conv_offset(conv_offset), .delay(delay),
    .light_val(light_val), .offs_val(offs_val),
    .conv_done(conv_done), .conv_data(conv_data));
  // ****************************************************
  // Access tasks
  // ****************************************************
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    step();
    `CHK("reg_rd_data", e, reg_rd_data)
  endtask
  task automatic trigger();
    light_single_shot_trigger = 1'b1;
    step();
    light_single_shot_trigger = 1'b0;
    step();
  endtask
  task automatic wait_valid();
    for (int i = 0; i < 4000; i++) begin
      step();
      if (light_result_valid === 1'b1) return;
    end
    errors++;
    $display("mismatch light_result_valid expected 1 seen 0");
  endtask
  function automatic logic [15:0] expv(input int avg, input bit off);
    logic [15:0] s;
    s = (avg == 0) ? light_val : light_val + 16'h0001;
    if (off) s = (s > offs_val) ? s - offs_val : 16'h0000;
    return s;
  endfunction
  function automatic int sps(input int c);
    return (c < 6) ? c + 1 : 8 + 2 * (c - 6);
  endfunction
  task automatic single(input int avg, input bit off);
    logic [15:0] e;
    reg_write(ALPR_CFG_ADDR, {4'h0, off, 3'(avg)});
    n0 = done_cnt;
    trigger();
    `CHK("light_busy", 1'b1, light_busy)
    wait_valid();
    `CHK("convs", (1 << avg) + int'(off), done_cnt - n0)
    e = expv(avg, off);
    reg_read(ALPR_RES_HI_ADDR, e[15:8]);
    reg_read(ALPR_RES_LO_ADDR, e[7:0]);
    `CHK("light_busy", 1'b0, light_busy)
  endtask
  task automatic period_convs(input int e);
    wait_valid();
    n0 = done_cnt;
    wait_valid();
    `CHK("period convs", e, done_cnt - n0)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    periodic_en = 1'b0;
    light_single_shot_trigger = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    delay = 4'h2;
    light_val = 16'h0100;
    offs_val = 16'h0030;
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    reg_read(ALPR_CFG_ADDR, 8'h0D);
    reg_write(ALPR_RES_HI_ADDR, 8'hA5);
    reg_write(ALPR_RES_LO_ADDR, 8'h5A);
    reg_read(ALPR_RES_HI_ADDR, 8'h00);
    reg_read(ALPR_RES_LO_ADDR, 8'h00);
    reg_read(ALPR_UNMAPPED, 8'h00);
    reg_write(ALPR_CFG_ADDR, 8'h72);
    reg_read(ALPR_CFG_ADDR, 8'h72);
    for (int off = 0; off < 2; off++) begin
      delay = off ? 4'h2 : 4'h9;
      for (int a = 0; a < 8; a++) single(a, off[0]);
    end
    light_val = 16'h0010;
    single(0, 1'b1);
    light_val = 16'h0100;
    for (int c = 0; c < 8; c++) begin
      reg_write(ALPR_CFG_ADDR, {1'b0, 3'(c), 4'h0});
      periodic_en = 1'b1;
      wait_valid();
      wait_valid();
      n0 = cyc;
      wait_valid();
      `CHK("period", CLK_P / sps(c), cyc - n0)
      periodic_en = 1'b0;
      step();
      step();
    end
    reg_write(ALPR_CFG_ADDR, 8'h70);
    periodic_en = 1'b1;
    wait_valid();
    step();
    trigger();
    `CHK("conv_req", 1'b0, conv_req)
    reg_write(ALPR_CFG_ADDR, 8'h72);
    period_convs(1);
    periodic_en = 1'b0;
    step();
    step();
    periodic_en = 1'b1;
    period_convs(4);
    periodic_en = 1'b0;
    step();
    step();
    reg_write(ALPR_CFG_ADDR, 8'h80);
    n0 = done_cnt;
    trigger();
    repeat (3) wait_valid();
    `CHK("cont convs", 3, done_cnt - n0)
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
